// ==== rtl/ard_pkg.sv ====
// register indices, field positions and reset values for the adc register dma engine
package ard_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CH_A       = 12'hFB0; // general channel a, five registers
	localparam logic [11:0] IDX_CH_B       = 12'hFB8; // general channel b, five registers
	localparam logic [11:0] IDX_ADC_CTL    = 12'hF70; // adc control
	localparam logic [11:0] IDX_DEST_BASE  = 12'hFBD; // adc_dest_base_addr
	localparam logic [11:0] IDX_ADC_DMA    = 12'hFBE; // adc dma control
	localparam logic [11:0] IDX_STATUS     = 12'hFBF; // read-only status
	// general channel register selects within its group
	localparam logic [2:0]  CH_IO          = 3'h0;
	localparam logic [2:0]  CH_HIGH        = 3'h1;
	localparam logic [2:0]  CH_START       = 3'h2;
	localparam logic [2:0]  CH_END         = 3'h3;
	localparam logic [2:0]  CH_CTL         = 3'h4;
	// general channel control fields
	localparam int          CTL_EN         = 0;
	localparam int          CTL_LOOP       = 1;
	localparam int          CTL_DIR        = 2;
	localparam int          CTL_IE         = 3;
	localparam int          CTL_WORD       = 4;
	localparam int          CTL_TRIG_LSB   = 5;
	localparam logic [3:0]  PERIPH_NIBBLE  = 4'hF;
	// adc control fields
	localparam int          ADC_START      = 7;
	localparam int          ADC_REF        = 5;
	localparam int          ADC_CONTINUOUS_CONVERSION       = 4;
	// adc dma control fields
	localparam int          DMA_EN         = 7;
	localparam int          DMA_IE         = 6;
	localparam logic [3:0]  INPUT_MAX      = 4'hB;
	// conversion timing in system clock cycles
	localparam int          CONV_SINGLE    = 5129;
	localparam int          CONV_CONTINUOUS_CONVERSION      = 256;
	// reset values
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [3:0]  RST_NIBBLE     = 4'h0;
	localparam logic [11:0] RST_ADDR       = 12'h000;
	localparam logic [15:0] RST_WORD       = 16'h0000;
	typedef enum logic [1:0] {OWN_NONE, OWN_ADC, OWN_A, OWN_B} ard_owner_t;
	typedef enum logic [2:0] {A_IDLE, A_REQ, A_HI, A_LO, A_REL} ard_adc_st_t;
	typedef enum logic [2:0] {G_IDLE, G_REQ, G_RD, G_CAP, G_WR} ard_gen_st_t;
endpackage : ard_pkg

// ==== rtl/ard_gen_channel.sv ====
// one general transfer channel between a peripheral register and register-file ram
`timescale 1ns/1ps
`default_nettype none
module ard_gen_channel
	import ard_pkg::*;
(
	input  wire logic        pclk,      // system clock
	input  wire logic        presetn,   // async reset, active low
	input  wire logic        reg_we,    // register write strobe
	input  wire logic [2:0]  reg_sel,   // register select in group
	input  wire logic [7:0]  reg_wdata, // register write data
	output logic      [7:0]  reg_rdata, // register read data
	input  wire logic [7:0]  trig,      // request trigger sources
	output logic             bus_req,   // system bus wanted
	input  wire logic        bus_gnt,   // system bus granted to us
	output logic      [11:0] mem_addr,  // bus address
	output logic      [7:0]  mem_wdata, // bus write data
	output logic             mem_we,    // bus write strobe
	output logic             mem_re,    // bus read strobe
	input  wire logic [7:0]  mem_rdata, // read data, one cycle after mem_re
	output logic             irq        // end-of-block pulse
);
	logic [7:0]  io_q, high_q, start_q, end_q, ctl_q, data_q;
	logic [11:0] cur_q;
	logic        second_q, irq_q;
	ard_gen_st_t st_q;

	//////////////////////////////////////////////////////////////////////////////
	wire [11:0] periph_addr = {PERIPH_NIBBLE, io_q + {7'h00, second_q}};
	wire [11:0] start_addr  = {high_q[3:0], start_q};
	wire [11:0] end_addr    = {high_q[7:4], end_q};
	wire        to_periph   = ctl_q[CTL_DIR];
	wire        at_end      = cur_q == end_addr;
	wire        fire        = ctl_q[CTL_EN] && trig[ctl_q[CTL_TRIG_LSB +: 3]];
	wire        last_byte   = at_end || !ctl_q[CTL_WORD] || second_q;
	wire        hw_disable  = st_q == G_WR && at_end && !ctl_q[CTL_LOOP];
	wire [11:0] src_addr    = to_periph ? cur_q : periph_addr;
	wire [11:0] dst_addr    = to_periph ? periph_addr : cur_q;

	assign bus_req   = st_q != G_IDLE;
	assign mem_re    = st_q == G_RD;
	assign mem_we    = st_q == G_WR;
	assign mem_addr  = mem_we ? dst_addr : src_addr;
	assign mem_wdata = data_q;
	assign irq       = irq_q;
	assign reg_rdata = reg_sel == CH_IO    ? io_q :
	                   reg_sel == CH_HIGH  ? high_q :
	                   reg_sel == CH_START ? cur_q[7:0] :
	                   reg_sel == CH_END   ? end_q : ctl_q;

	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			io_q <= RST_BYTE;
			high_q <= RST_BYTE;
			start_q <= RST_BYTE;
			end_q <= RST_BYTE;
		end
		else if (reg_we)
		begin
			if (reg_sel == CH_IO) io_q <= reg_wdata;
			if (reg_sel == CH_HIGH) high_q <= reg_wdata;
			if (reg_sel == CH_START) start_q <= reg_wdata;
			if (reg_sel == CH_END) end_q <= reg_wdata;
		end
	end

	// a software write of the control register wins over the hardware disable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctl_q <= RST_BYTE;
		else if (reg_we && reg_sel == CH_CTL)
			ctl_q <= reg_wdata;
		else if (hw_disable)
			ctl_q[CTL_EN] <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= G_IDLE;
			cur_q <= RST_ADDR;
			data_q <= RST_BYTE;
			second_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= 1'b0;
			if (reg_we && reg_sel == CH_START)
				cur_q <= {high_q[3:0], reg_wdata};
			case (st_q)
				G_IDLE: if (fire) st_q <= G_REQ;
				G_REQ: if (bus_gnt) st_q <= G_RD;
				G_RD: st_q <= G_CAP;
				G_CAP:
				begin
					data_q <= mem_rdata;
					st_q <= G_WR;
				end
				G_WR:
				begin
					cur_q <= at_end ? start_addr : cur_q + 12'h001;
					irq_q <= at_end && ctl_q[CTL_IE];
					second_q <= !last_byte;
					st_q <= last_byte ? G_IDLE : G_RD;
				end
				default: st_q <= G_IDLE;
			endcase
		end
	end

	a_periph_nibble: assert property (@(posedge pclk) disable iff (!presetn)
		(mem_we && to_periph) |-> mem_addr[11:8] == PERIPH_NIBBLE)
		else $error("peripheral address upper nibble is not all ones");
endmodule : ard_gen_channel
`default_nettype wire

// ==== rtl/ard_dma_engine.sv ====
// adc register dma engine: apb registers, adc control, adc and general channels
//
// Overview of operation
// - peripheral address is all-ones nibble over byte
// - start and end addresses from high nibbles
// - control selects loop, direction, irq, size, trigger
// - conversion completion signals the adc transfer channel
// - request bus, wait for cpu acknowledge first
// - write both result bytes, then release bus
// - after highest input, restart on input zero
// - interrupt after highest input when enabled
// - destination is base[7:1], input, zero
// - start bit reads one until conversion completes
// - start during conversion restarts it
// - reference bit zero enables internal reference
// - single conversion completes after 5129 cycles
// - continuous conversion updates every 256 cycles
// - input codes 0 to 11 valid, 11XX reserved
`timescale 1ns/1ps
`default_nettype none
module ard_dma_engine
	import ard_pkg::*;
#(
	parameter int        CONV_SINGLE_CYCLES = CONV_SINGLE, // single conversion length
	parameter int        RESULT_W           = 16            // converter result width
) (
	input  wire logic                pclk,          // system clock, 20 MHz
	input  wire logic                presetn,       // async reset, active low
	input  wire logic                psel,          // apb select
	input  wire logic                penable,       // apb access phase
	input  wire logic                pwrite,        // apb write
	input  wire logic [15:0]         paddr,         // apb byte address
	input  wire logic [31:0]         pwdata,        // apb write data
	output logic      [31:0]         prdata,        // apb read data
	output logic                     pready,        // apb ready
	output logic                     pslverr,       // apb error, unmapped address
	output logic                     bus_req_o,     // system bus request to cpu
	input  wire logic                bus_ack_i,     // cpu acknowledges bus request
	output logic      [11:0]         mem_addr_o,    // register-file address
	output logic      [7:0]          mem_wdata_o,   // register-file write data
	output logic                     mem_we_o,      // register-file write strobe
	output logic                     mem_re_o,      // register-file read strobe
	input  wire logic [7:0]          mem_rdata_i,   // read data, one cycle later
	input  wire logic [7:0]          periph_trig_i, // general channel triggers
	output logic      [1:0]          chan_irq_o,    // general channel irq pulses
	output logic                     adc_irq_o,     // adc transfer irq pulse
	input  wire logic [RESULT_W-1:0] adc_sample_i,  // converter output value
	output logic      [3:0]          adc_input_o,   // analog input being converted
	output logic                     adc_ref_int_o, // internal reference enable
	output logic                     adc_continuous_conversion_o,    // continuous conversion mode
	output logic                     adc_busy_o     // conversion running
);
	localparam logic [12:0] LEN_SINGLE = 13'(CONV_SINGLE_CYCLES - 1);
	localparam logic [12:0] LEN_CONTINUOUS_CONVERSION   = 13'(CONV_CONTINUOUS_CONVERSION - 1);

	logic [7:0]          adc_ctl_q, base_q, dma_ctl_q, rd_mux;
	logic [31:0]         prdata_q;
	logic                start_q, run_q, dma_restart, conv_done;
	logic [12:0]         cnt_q, since_q;
	logic [3:0]          conv_in_q, scan_q, xfer_in_q;
	logic [RESULT_W-1:0] result_q;
	logic                adc_irq_q;
	ard_adc_st_t         ast_q;
	ard_owner_t          own_q;

	//////////////////////////////////////////////////////////////////////////////
	// apb decode; zero wait states, read data captured in the setup phase
	wire [11:0] idx        = paddr[13:2];
	wire        addr_ok    = paddr[15:14] == 2'h0 && paddr[1:0] == 2'h0;
	wire        hit_ctl    = addr_ok && idx == IDX_ADC_CTL;
	wire        hit_base   = addr_ok && idx == IDX_DEST_BASE;
	wire        hit_dma    = addr_ok && idx == IDX_ADC_DMA;
	wire        hit_stat   = addr_ok && idx == IDX_STATUS;
	wire        hit_a      = addr_ok && idx[11:3] == IDX_CH_A[11:3] && idx[2:0] <= CH_CTL;
	wire        hit_b      = addr_ok && idx[11:3] == IDX_CH_B[11:3] && idx[2:0] <= CH_CTL;
	wire        mapped     = hit_ctl || hit_base || hit_dma || hit_stat || hit_a || hit_b;
	wire        setup      = psel && !penable;
	wire        wr_acc     = psel && penable && pwrite && mapped;
	wire        dma_busy   = ast_q != A_IDLE;
	wire [7:0]  status     = {2'h0, dma_busy, run_q, scan_q};
	wire [7:0]  ch_rdata [2];

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_q;
	assign rd_mux  = hit_ctl  ? {start_q, adc_ctl_q[6:0]} :
	                 hit_base ? base_q :
	                 hit_dma  ? dma_ctl_q :
	                 hit_stat ? status :
	                 hit_a    ? ch_rdata[0] :
	                 hit_b    ? ch_rdata[1] : RST_BYTE;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup)
			prdata_q <= {24'h00_0000, rd_mux};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_ctl_q <= RST_BYTE;
			base_q <= RST_BYTE;
			dma_ctl_q <= RST_BYTE;
		end
		else if (wr_acc)
		begin
			if (hit_ctl) adc_ctl_q <= {1'b0, pwdata[6:0]};
			if (hit_base) base_q <= pwdata[7:0];
			if (hit_dma) dma_ctl_q <= pwdata[7:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// conversion timing
	wire [3:0]  sel_in     = adc_ctl_q[3:0];
	wire [3:0]  wr_sel     = pwdata[3:0];
	wire        dma_on     = dma_ctl_q[DMA_EN];
	wire [3:0]  last_in    = dma_ctl_q[3:0] > INPUT_MAX ? INPUT_MAX : dma_ctl_q[3:0];
	// next scan input; scan_q only takes it on the restart edge, so the restart reads this
	wire [3:0]  scan_next  = xfer_in_q == last_in ? RST_NIBBLE : xfer_in_q + 4'h1;
	wire        sw_start   = wr_acc && hit_ctl && pwdata[ADC_START] &&
	                         (dma_on || wr_sel <= INPUT_MAX);
	wire [3:0]  next_in    = dma_on ? scan_q : wr_sel;
	wire        continuous_conversion_on    = adc_ctl_q[ADC_CONTINUOUS_CONVERSION];
	wire [12:0] conv_len   = continuous_conversion_on ? LEN_CONTINUOUS_CONVERSION : LEN_SINGLE;
	wire        any_start  = sw_start || dma_restart;

	assign conv_done     = run_q && cnt_q == conv_len && !any_start;
	assign adc_input_o   = conv_in_q;
	assign adc_ref_int_o = !adc_ctl_q[ADC_REF];
	assign adc_continuous_conversion_o    = continuous_conversion_on;
	assign adc_busy_o    = run_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 13'h0000;
			run_q <= 1'b0;
			start_q <= 1'b0;
			conv_in_q <= RST_NIBBLE;
			result_q <= RESULT_W'(0);
		end
		else if (any_start)
		begin
			cnt_q <= 13'h0000;
			run_q <= 1'b1;
			start_q <= 1'b1;
			conv_in_q <= dma_restart ? scan_next : next_in;
		end
		else if (conv_done)
		begin
			cnt_q <= 13'h0000;
			run_q <= continuous_conversion_on;
			start_q <= 1'b0;
			result_q <= adc_sample_i;
		end
		else if (run_q)
			cnt_q <= cnt_q + 13'h0001;
	end

	//////////////////////////////////////////////////////////////////////////////
	// adc transfer channel
	wire        adc_req    = ast_q == A_REQ || ast_q == A_HI || ast_q == A_LO;
	wire        adc_gnt    = bus_ack_i && own_q == OWN_ADC;
	wire        at_last    = xfer_in_q == last_in;
	wire [11:0] adc_dest   = {base_q[7:1], xfer_in_q, 1'b0};
	wire [11:0] adc_addr   = ast_q == A_LO ? adc_dest | 12'h001 : adc_dest;
	wire [7:0]  adc_byte   = ast_q == A_HI ? 8'(result_q >> 8) : result_q[7:0];

	assign dma_restart = ast_q == A_REL;
	assign adc_irq_o   = adc_irq_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ast_q <= A_IDLE;
			scan_q <= RST_NIBBLE;
			xfer_in_q <= RST_NIBBLE;
			adc_irq_q <= 1'b0;
		end
		else
		begin
			adc_irq_q <= 1'b0;
			if (!dma_on && ast_q == A_IDLE)
				scan_q <= RST_NIBBLE;
			case (ast_q)
				A_IDLE:
				if (conv_done && dma_on)
				begin
					xfer_in_q <= conv_in_q;
					ast_q <= A_REQ;
				end
				A_REQ: if (adc_gnt) ast_q <= A_HI;
				A_HI: ast_q <= A_LO;
				A_LO: ast_q <= A_REL;
				A_REL:
				begin
					scan_q <= scan_next;
					adc_irq_q <= at_last && dma_ctl_q[DMA_IE];
					ast_q <= A_IDLE;
				end
				default: ast_q <= A_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// general channels and system bus ownership
	wire        ch_req   [2];
	wire [11:0] ch_addr  [2];
	wire [7:0]  ch_wdata [2];
	wire        ch_we    [2];
	wire        ch_re    [2];
	wire [1:0]  ch_gnt   = {bus_ack_i && own_q == OWN_B, bus_ack_i && own_q == OWN_A};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_chan
			ard_gen_channel u_chan (
				.pclk      (pclk),
				.presetn   (presetn),
				.reg_we    (wr_acc && (gi == 0 ? hit_a : hit_b)),
				.reg_sel   (idx[2:0]),
				.reg_wdata (pwdata[7:0]),
				.reg_rdata (ch_rdata[gi]),
				.trig      (periph_trig_i),
				.bus_req   (ch_req[gi]),
				.bus_gnt   (ch_gnt[gi]),
				.mem_addr  (ch_addr[gi]),
				.mem_wdata (ch_wdata[gi]),
				.mem_we    (ch_we[gi]),
				.mem_re    (ch_re[gi]),
				.mem_rdata (mem_rdata_i),
				.irq       (chan_irq_o[gi])
			);
		end
	endgenerate

	// the owner keeps the bus until its own request drops; adc has priority
	wire own_done = (own_q == OWN_ADC && !adc_req) || (own_q == OWN_A && !ch_req[0]) ||
	                (own_q == OWN_B && !ch_req[1]);
	wire is_a     = own_q == OWN_A;
	wire is_b     = own_q == OWN_B;
	wire is_adc   = own_q == OWN_ADC;

	assign bus_req_o   = adc_req || ch_req[0] || ch_req[1];
	assign mem_we_o    = (is_adc && (ast_q == A_HI || ast_q == A_LO)) ||
	                     (is_a && ch_we[0]) || (is_b && ch_we[1]);
	assign mem_re_o    = (is_a && ch_re[0]) || (is_b && ch_re[1]);
	assign mem_addr_o  = is_adc ? adc_addr : is_a ? ch_addr[0] : is_b ? ch_addr[1] : RST_ADDR;
	assign mem_wdata_o = is_adc ? adc_byte : is_a ? ch_wdata[0] : is_b ? ch_wdata[1] : RST_BYTE;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			own_q <= OWN_NONE;
		else if (own_q == OWN_NONE || own_done)
			own_q <= adc_req ? OWN_ADC : ch_req[0] ? OWN_A : ch_req[1] ? OWN_B : OWN_NONE;
	end

	//////////////////////////////////////////////////////////////////////////////
	// helper: cycles since the last start or completion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			since_q <= 13'h0000;
		else if (any_start || conv_done)
			since_q <= 13'h0000;
		else if (since_q != 13'h1FFF)
			since_q <= since_q + 13'h0001;
	end

	sequence s_two_bytes;
		ast_q == A_HI ##1 ast_q == A_LO ##1 ast_q == A_REL;
	endsequence

	a_base_addr_form: assert property (@(posedge pclk) disable iff (!presetn)
		(mem_we_o && is_adc) |-> mem_addr_o[11:5] == base_q[7:1] &&
		mem_addr_o[4:1] == xfer_in_q)
		else $error("adc destination address malformed");
	a_no_xfer_wo_ack: assert property (@(posedge pclk) disable iff (!presetn)
		(mem_we_o || mem_re_o) |-> bus_ack_i && bus_req_o)
		else $error("bus used without cpu acknowledge");
	a_both_bytes: assert property (@(posedge pclk) disable iff (!presetn)
		(ast_q == A_REQ && adc_gnt) |=> s_two_bytes)
		else $error("adc result bytes not written in order");
	a_release_bus: assert property (@(posedge pclk) disable iff (!presetn)
		ast_q == A_LO |=> !adc_req ##1 !adc_req)
		else $error("adc channel kept the bus");
	a_byte_order: assert property (@(posedge pclk) disable iff (!presetn)
		(ast_q == A_HI && mem_we_o) |-> !mem_addr_o[0] ##1 mem_addr_o[0] &&
		mem_wdata_o == $past(result_q[7:0]))
		else $error("result byte order wrong");
	a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(ast_q == A_REL && at_last) |=> scan_q == 4'h0 && run_q && conv_in_q == 4'h0)
		else $error("scan did not restart on input zero");
	a_next_input: assert property (@(posedge pclk) disable iff (!presetn)
		(ast_q == A_REL && !at_last) |=> scan_q == $past(xfer_in_q) + 4'h1)
		else $error("scan did not step to next input");
	a_irq_on_last: assert property (@(posedge pclk) disable iff (!presetn)
		(ast_q == A_REL) |=> adc_irq_o == ($past(at_last) && dma_ctl_q[DMA_IE]))
		else $error("adc interrupt wrong");
	a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
		conv_done |-> since_q == (continuous_conversion_on ? LEN_CONTINUOUS_CONVERSION : LEN_SINGLE))
		else $error("conversion length wrong");
	a_start_reads: assert property (@(posedge pclk) disable iff (!presetn)
		any_start |=> start_q && cnt_q == 13'h0000 ##1 start_q)
		else $error("start bit or restart wrong");
	a_ref_select: assert property (@(posedge pclk) disable iff (!presetn)
		adc_ref_int_o != adc_ctl_q[ADC_REF])
		else $error("reference enable inverted");
	a_reserved_sel: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && hit_ctl && !dma_on && pwdata[3:2] == 2'h3 && !run_q) |=> !run_q)
		else $error("reserved input started a conversion");

	//////////////////////////////////////////////////////////////////////////////
	// converter, scan and interrupt sequencing
	a_req_on_done: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_done && dma_on && ast_q == A_IDLE) |=> bus_req_o)
		else $error("finished conversion did not request the bus");
	a_wait_ack: assert property (@(posedge pclk) disable iff (!presetn)
		(ast_q == A_REQ && !adc_gnt) |=> ast_q == A_REQ)
		else $error("adc channel moved on without acknowledge");
	a_scan_restart: assert property (@(posedge pclk) disable iff (!presetn)
		dma_restart |=> run_q && conv_in_q == scan_q)
		else $error("restart converts another input than the scan holds");
	a_irq_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		adc_irq_o |=> !adc_irq_o)
		else $error("adc interrupt longer than one cycle");
	a_continuous_conversion_rerun: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_done && continuous_conversion_on) |=> run_q)
		else $error("continuous conversion stopped");
	a_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_done && !continuous_conversion_on) |=> !run_q && !start_q)
		else $error("single conversion kept running");
	a_chan_irq_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		chan_irq_o[0] |=> !chan_irq_o[0])
		else $error("channel interrupt longer than one cycle");
endmodule : ard_dma_engine
`default_nettype wire

// ==== dv/ard_cpu_model.sv ====
// cpu bus-grant and register-file read model facing the dma engine
`timescale 1ns/1ps
`default_nettype none
module ard_cpu_model
(
	input  wire logic        pclk,     // system clock
	input  wire logic        presetn,  // async reset, active low
	input  wire logic        bus_req,  // bus wanted by dma
	output logic             bus_ack,  // grant, held while requested
	input  wire logic        mem_re,   // read strobe
	input  wire logic [11:0] mem_addr, // read address
	output logic      [7:0]  mem_rdata // read data, one cycle later
);
	int unsigned lag;
	// first grant is prompt, later ones stall 0..5 cycles
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			bus_ack <= 1'b0;
			lag     <= 0;
		end
		else if (!bus_req)
			bus_ack <= 1'b0;
		else if (!bus_ack && lag == 0)
		begin
			bus_ack <= 1'b1;
			lag     <= $urandom_range(5, 0);
		end
		else if (!bus_ack)
			lag <= lag - 1;
	// stale data inverted so nothing leans on a held value
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			mem_rdata <= 8'h00;
		else
			mem_rdata <= mem_re ? (mem_addr[7:0] ^ 8'h5A) : ~mem_rdata;
endmodule : ard_cpu_model
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the adc register dma engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED %0t: got %0h want %0h", $time, a, e); end end
module testbench
	import ard_pkg::*;
;
	localparam int CONV = 20;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_req, bus_ack;
	logic        mem_we, mem_re, adc_irq, adc_ref_int, adc_continuous_conversion, adc_busy;
	logic [15:0] paddr, adc_sample;
	logic [31:0] pwdata, prdata;
	logic [11:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata, trig, base;
	logic [1:0]  chan_irq;
	logic [3:0]  adc_input, ev;
	logic [7:0]  rd_q[$];
	logic [20:0] wr_q[$];
	int          err_total, cmp_count, n;
	assign ev = {adc_irq, chan_irq, adc_busy};
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	ard_dma_engine #(.CONV_SINGLE_CYCLES(CONV)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_req_o(bus_req),
		.bus_ack_i(bus_ack), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we),
		.mem_re_o(mem_re), .mem_rdata_i(mem_rdata), .periph_trig_i(trig),
		.chan_irq_o(chan_irq), .adc_irq_o(adc_irq), .adc_sample_i(adc_sample),
		.adc_input_o(adc_input), .adc_ref_int_o(adc_ref_int), .adc_continuous_conversion_o(adc_continuous_conversion),
		.adc_busy_o(adc_busy));
	ard_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .bus_ack(bus_ack),
		.mem_re(mem_re), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
	////////////////////////////////////////////////////////////////////////////////
	// result watcher: oldest note against what appears
	// notes popped once into holders: the check macro names its operands twice
	always @(posedge pclk)
	begin : watch
		logic [7:0]  rd_exp;
		logic [20:0] wr_exp;
		if (psel && penable && pready && !pwrite)
		begin
			rd_exp = rd_q.pop_front();
			`CHK(prdata, {24'h0, rd_exp})
		end
		if (psel && penable && paddr == 16'h0000)
			`CHK(pslverr, 1'b1)
		if (mem_we || mem_re)
		begin
			wr_exp = wr_q.pop_front();
			`CHK({mem_we, mem_addr, mem_we ? mem_wdata : 8'h00}, wr_exp)
			`CHK({bus_req, bus_ack}, 2'b11)
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] idx, input logic [7:0] e);
		rd_q.push_back(e);
		apb(1'b0, idx, 8'h00);
	endtask : rd
	// count falling edges until an event bit reaches a level
	task automatic waitev(input int b, input logic lvl);
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (ev[b] !== lvl && n < 2000);
		// a wait that runs out counts as a mismatch
		`CHK(ev[b], lvl)
	endtask : waitev
	task automatic gen(input logic [11:0] g, input logic [7:0] io, hi, st, en, ctl, t,
		input int b);
		apb(1'b1, g + 12'(CH_IO), io);
		apb(1'b1, g + 12'(CH_HIGH), hi);
		apb(1'b1, g + 12'(CH_START), st);
		apb(1'b1, g + 12'(CH_END), en);
		apb(1'b1, g + 12'(CH_CTL), ctl);
		trig <= t;
		waitev(b, 1'b1);
		`CHK(wr_q.size(), 0)
		@(posedge pclk);
		trig <= 8'h00;
	endtask : gen
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#3000000;
		err_total++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hFCABBC55));
		{presetn, psel, penable, pwrite, paddr, pwdata, trig, adc_sample} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(adc_ref_int, 1'b1)
		rd(IDX_DEST_BASE, 8'h00);
		rd(12'h000, 8'h00);
		apb(1'b1, IDX_ADC_CTL, 8'h30);
		@(negedge pclk);
		`CHK({adc_ref_int, adc_continuous_conversion}, 2'b01)
		apb(1'b1, IDX_ADC_CTL, 8'h00);
		@(negedge pclk);
		`CHK({adc_ref_int, adc_continuous_conversion}, 2'b10)
		apb(1'b1, IDX_ADC_CTL, 8'h8C);
		@(negedge pclk);
		`CHK(adc_busy, 1'b0)
		// restart midway, then the full length must run again
		apb(1'b1, IDX_ADC_CTL, 8'h83);
		rd(IDX_ADC_CTL, 8'h83);
		apb(1'b1, IDX_ADC_CTL, 8'h83);
		waitev(0, 1'b0);
		// n also counts the falling edge right after the restart edge
		`CHK(n, CONV + 1)
		rd(IDX_ADC_CTL, 8'h03);
		// scan of inputs 0..2, interrupt after the last
		adc_sample <= 16'($urandom);
		base = 8'($urandom) & 8'hFE;
		apb(1'b1, IDX_DEST_BASE, base);
		apb(1'b1, IDX_ADC_DMA, 8'hC2);
		for (int i = 0; i < 3; i++)
		begin
			wr_q.push_back({1'b1, base[7:1], i[3:0], 1'b0, adc_sample[15:8]});
			wr_q.push_back({1'b1, base[7:1], i[3:0], 1'b1, adc_sample[7:0]});
		end
		apb(1'b1, IDX_ADC_CTL, 8'h80);
		waitev(3, 1'b1);
		`CHK(adc_input, 4'h0)
		`CHK(wr_q.size(), 0)
		apb(1'b1, IDX_ADC_DMA, 8'h00);
		wr_q = {21'h0F4200, 21'h131018, 21'h0F4200, 21'h131118};
		gen(IDX_CH_A, 8'h42, 8'h33, 8'h10, 8'h11, 8'h09, 8'h01, 1);
		wr_q = {21'h042000, 21'h1F807A};
		gen(IDX_CH_B, 8'h80, 8'h44, 8'h20, 8'h20, 8'h2D, 8'h02, 2);
		// continuous run on input 1: start bit falls after the first result, run goes on
		apb(1'b1, IDX_ADC_CTL, 8'h91);
		repeat (200) @(posedge pclk);
		rd(IDX_ADC_CTL, 8'h91);
		repeat (100) @(posedge pclk);
		rd(IDX_ADC_CTL, 8'h11);
		`CHK({adc_busy, adc_input}, 5'h11)
		repeat (40) @(posedge pclk);
		`CHK(wr_q.size(), 0)
		`CHK(bus_req, 1'b0)
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
